// ### bench/dacs_host_model.sv
// Host serial master model that shifts command frames into the register bank.
// Assumes the bench calls one task at a time and never overlaps two frames.
module dacs_host_model #(
  parameter int HALF_NS = 16
) (
  output logic o_serial_clock,
  output logic o_chip_select_n,
  output logic o_serial_data_in,
  input wire logic i_serial_data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Current clock mode; the bench reads pha to pick the readback bits.
  logic pol = 1'b0;
  logic pha = 1'b0;

  // The serial clock stands still at its idle level outside frames.
  initial begin
    o_serial_clock = 1'b0;
    o_chip_select_n = 1'b1;
    o_serial_data_in = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // host clock mode
  // The idle level moves only while deselected, then the link settles.
  task automatic set_mode(input logic p, input logic h);
    pol = p;
    pha = h;
    o_serial_clock = p;
    #(4 * HALF_NS);
  endtask : set_mode

  ////////////////////////////////////////////////////////////////////////////
  // frame shift
  // Bits go top first; phase 0 sets data before the first edge and samples
  // on it, phase 1 launches on the first edge and samples on the second.
  task automatic frame(input logic [15:0] word, output logic [15:0] rx);
    o_chip_select_n = 1'b0;
    #(HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      if (!pha) o_serial_data_in = word[i];
      #(HALF_NS);
      if (!pha) rx[i] = i_serial_data_out;
      o_serial_clock = ~o_serial_clock;
      if (pha) o_serial_data_in = word[i];
      #(HALF_NS);
      if (pha) rx[i] = i_serial_data_out;
      o_serial_clock = ~o_serial_clock;
    end
    #(HALF_NS);
    o_chip_select_n = 1'b1;
    // A released line shows the inverse, so a stale bit never looks valid.
    o_serial_data_in = ~o_serial_data_in;
    #(8 * HALF_NS);
  endtask : frame
endmodule : dacs_host_model

// ### bench/dacs_regs_bench.sv
// Self-checking bench for the converter register bank.
// Assumes the host model beside it and the shared constants header.
`include "dacs_params.svh"

module dacs_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wide_read_active = 1'b0;
  logic i_averaging_busy = 1'b0;
  logic sclk, cs_n, sdi, sdo, pol, pha;
  dacs_pkg::dacs_power_s o_power;
  dacs_pkg::dacs_readout_e o_readout_mode;
  logic [1:0] lane;
  logic [7:0] status;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hc701a7d8;
  logic [15:0] rx;
  logic [7:0] d;
  logic [4:0] m;

  // System clock at 100 MHz; the host link runs at 32 ns on its own.
  always #5 i_clock = ~i_clock;

  dacs_regs DUT (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_serial_clock(sclk),
    .i_chip_select_n(cs_n), .i_serial_data_in(sdi),
    .i_wide_read_active(i_wide_read_active),
    .i_averaging_busy(i_averaging_busy), .o_serial_data_out(sdo),
    .o_power(o_power), .o_readout_mode(o_readout_mode),
    .o_serial_clock_polarity(pol), .o_serial_clock_phase(pha),
    .o_output_lane_width(lane), .o_status(status)
  );

  dacs_host_model HOST (
    .o_serial_clock(sclk), .o_chip_select_n(cs_n),
    .o_serial_data_in(sdi), .i_serial_data_out(sdo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and expectation helpers.
  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Galois shift register gives repeatable stimulus from the fixed seed.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr_next

  // Top protocol bit wins over the two lower ones.
  function automatic logic [4:0] mode_exp(input logic [2:0] p);
    if (p[2]) return 5'h10;
    return 5'h01 << p[1:0];
  endfunction : mode_exp

  // One frame, then enough system cycles for the update to land.
  task automatic wr(input logic [3:0] c, input logic [3:0] a,
                    input logic [7:0] v);
    HOST.frame({c, a, v}, rx);
    repeat (4) @(negedge i_clock);
  endtask : wr

  // The answer rides on the following frame; phase 0 sees it a bit late.
  task automatic rd(input logic [3:0] a, input logic [7:0] exp,
                    input string name);
    HOST.frame({`DACS_CMD_READ, a, 8'h00}, rx);
    HOST.frame(16'h0000, rx);
    check(name, 16'(HOST.pha ? rx[15:8] : rx[14:7]), 16'(exp));
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // A hang is cut short well above the expected run of some 5000 cycles.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (8) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    check("power", 16'(o_power), 16'h0000);
    check("mode", 16'(o_readout_mode), 16'h0001);
    check("status", 16'(status), 16'h0000);
    for (int a = 0; a < `DACS_REG_COUNT; a++) begin
      rd(a[3:0], `DACS_RESET_VALUE, "reset_rb");
    end
    // reserved bits kept zero in random writes.
    for (int k = 0; k < 6; k++) begin
      seed = lfsr_next(seed);
      d = seed[7:0] & `DACS_MASK_POWER;
      wr(`DACS_CMD_WRITE, `DACS_ADDR_POWER, d);
      check("power", 16'(o_power), 16'({d[5], d[3], d[1:0]}));
      rd(`DACS_ADDR_POWER, d, "power_rb");
    end
    // Set and clear commands touch only the bits given as ones.
    wr(`DACS_CMD_WRITE, `DACS_ADDR_POWER, 8'h0a);
    wr(`DACS_CMD_SET, `DACS_ADDR_POWER, 8'h21);
    check("set", 16'(o_power), 16'h000f);
    wr(`DACS_CMD_CLEAR, `DACS_ADDR_POWER, 8'h0a);
    check("clear", 16'(o_power), 16'h0009);
    // Unknown command and unmapped address change and return nothing.
    wr(4'h3, `DACS_ADDR_POWER, 8'h2b);
    check("nop", 16'(o_power), 16'h0009);
    rd(4'h5, 8'h00, "unmapped_rb");
    // Every protocol code, cycling all four clock modes on the way.
    for (int p = 0; p < 8; p++) begin
      d = {1'b0, p[2:0], 2'b00, p[1:0]};
      wr(`DACS_CMD_WRITE, `DACS_ADDR_PROTOCOL, d);
      HOST.set_mode(p[1], p[0]);
      m = mode_exp(p[2:0]);
      check("mode", 16'(o_readout_mode), 16'(m));
      check("clock", 16'({pol, pha}), 16'(p[1:0]));
      seed = lfsr_next(seed);
      wr(`DACS_CMD_WRITE, `DACS_ADDR_WIDTH, seed[7:0] & `DACS_MASK_WIDTH);
      check("lane", 16'(lane), 16'(seed[1:0]));
      rd(`DACS_ADDR_PROTOCOL, d, "proto_rb");
    end
    wr(`DACS_CMD_WRITE, `DACS_ADDR_PROTOCOL, 8'h00);
    HOST.set_mode(1'b0, 1'b0);
    // Sticky flags: a one-cycle wide read, then a frame during averaging.
    @(negedge i_clock) i_wide_read_active = 1'b1;
    @(negedge i_clock) i_wide_read_active = 1'b0;
    repeat (4) @(negedge i_clock);
    check("wide", 16'(status), 16'h0004);
    i_averaging_busy = 1'b1;
    wr(4'h0, 4'h0, 8'h00);
    i_averaging_busy = 1'b0;
    check("abort", 16'(status), 16'h0006);
    wr(`DACS_CMD_WRITE, `DACS_ADDR_STATUS, 8'h04);
    check("w1c", 16'(status), 16'h0002);
    wr(`DACS_CMD_SET, `DACS_ADDR_STATUS, 8'h02);
    check("w1c", 16'(status), 16'h0000);
    rd(`DACS_ADDR_STATUS, 8'h00, "status_rb");
    // A second reset in mid-run must clear registers and flags again.
    wr(`DACS_CMD_WRITE, `DACS_ADDR_WIDTH, 8'h03);
    @(negedge i_clock) i_wide_read_active = 1'b1;
    @(negedge i_clock) i_wide_read_active = 1'b0;
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    check("power", 16'(o_power), 16'h0000);
    check("lane", 16'(lane), 16'h0000);
    check("status", 16'(status), 16'h0000);
    rd(`DACS_ADDR_WIDTH, 8'h00, "reset_rb");
    print_verdict();
  end
endmodule : dacs_regs_bench

// ### hw/dacs_regs.sv
// Configuration and status registers of the dual converter, with the
// serial command port that reaches them.
// Assumes the host drives chip select, serial clock and serial data in,
// and that the sampling logic raises its event inputs on i_clock.
//
// Overview of operation
// - Wide read cycle sets sticky status bit 2.
// - Chip select during averaging sets bit 1.
// - Power-down bit 5 switches half reference off.
// - Bit 3 powers down second channel, buffer.
// - Bit 1 powers down first channel, buffer.
// - Bit 0 powers down the internal reference.
// - Protocol 000b selects serial single data rate.
// - Protocol 001b selects serial double data rate.
// - Protocol 010b selects retimer single data rate.
// - Protocol 011b selects retimer double data rate.
// - Protocol top bit set selects parallel bytes.
// - Protocol bit 1 sets serial clock polarity.
// - Protocol bit 0 sets serial clock phase.
// - All four registers reset to zero.
// - Command 0001 writes addressed register data.
// - Command 0010 returns data next frame.
// - Command 0101 sets ones; clears status flags.
// - Command 0110 clears bits given as ones.
`include "dacs_params.svh"

module dacs_regs (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_serial_clock,
  input wire logic i_chip_select_n,
  input wire logic i_serial_data_in,
  input wire logic i_wide_read_active,
  input wire logic i_averaging_busy,
  output logic o_serial_data_out,
  output dacs_pkg::dacs_power_s o_power,
  output dacs_pkg::dacs_readout_e o_readout_mode,
  output logic o_serial_clock_polarity,
  output logic o_serial_clock_phase,
  output logic [1:0] o_output_lane_width,
  output logic [7:0] o_status
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Stored configuration registers; status lives apart, so address 0 has
  // no entry here.
  logic [7:0] cfg [1:`DACS_REG_COUNT-1];
  // Sticky status flags.
  logic wide_read_flag;
  logic averaging_abort_flag;
  // Byte returned during the frame after a read command.
  logic [7:0] read_byte;
  // Sampling edge choice, registered from polarity and phase.
  logic edge_select;
  // Link-side clocks and reset.
  logic sample_clock;
  logic link_rst_n;
  // Link-side shift state.
  logic [14:0] shift_in;
  logic [4:0] bit_count;
  logic [3:0] out_count;
  dacs_pkg::dacs_frame_s frame_word;
  logic frame_toggle;
  // System-side view of the link.
  logic [1:0] synced;
  logic toggle_seen;
  logic cs_active_prev;
  logic frame_strobe;
  logic cs_fall;
  logic status_clear_hit;
  logic [7:0] status_clear;
  logic [7:0] view [`DACS_REG_COUNT];

  //////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Writable bits of each address; unmapped addresses have none.
  function automatic logic [7:0] writable(input logic [3:0] addr);
    case (addr)
      `DACS_ADDR_STATUS: writable = `DACS_MASK_STATUS;
      `DACS_ADDR_POWER: writable = `DACS_MASK_POWER;
      `DACS_ADDR_PROTOCOL: writable = `DACS_MASK_PROTOCOL;
      `DACS_ADDR_WIDTH: writable = `DACS_MASK_WIDTH;
      default: writable = 8'h00;
    endcase
  endfunction : writable

  // New register value for a command; reserved bits stay zero.
  function automatic logic [7:0] updated(input logic [7:0] old,
                                         input dacs_pkg::dacs_frame_s f);
    logic [7:0] value;
    value = old;
    case (f.cmd)
      `DACS_CMD_WRITE: value = f.data;
      `DACS_CMD_SET: value = old | f.data;
      `DACS_CMD_CLEAR: value = old & ~f.data;
      default: value = old;
    endcase
    updated = value & writable(f.addr);
  endfunction : updated

  // True for the three commands that modify a register.
  function automatic logic is_modify(input logic [3:0] cmd);
    is_modify = (cmd == `DACS_CMD_WRITE) || (cmd == `DACS_CMD_SET) ||
                (cmd == `DACS_CMD_CLEAR);
  endfunction : is_modify

  //////////////////////////////////////////////////////////////////////////
  // Link domain: serial clock edges inside a frame.

  // edge choice
  // Modes 0 and 3 sample on the rising edge, 1 and 2 on the falling one.
  // The select only changes between frames, so the clock mux is glitch
  // free in normal use; the host must idle before reprogramming it.
  assign sample_clock = i_serial_clock ^ edge_select;

  // A high chip select holds the frame logic in reset, ending each frame.
  assign link_rst_n = i_rst_n & ~i_chip_select_n;

  // Shift the incoming bits and count them; extra bits are ignored.
  always_ff @(posedge sample_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_in <= 15'h0000;
      bit_count <= 5'h00;
    end else if (bit_count != `DACS_FRAME_BITS) begin
      shift_in <= {shift_in[13:0], i_serial_data_in};
      bit_count <= bit_count + 5'h01;
    end
  end

  // Capture the whole frame and flag it with a toggle. The word is held
  // until the next frame completes, so the system side reads it stable.
  always_ff @(posedge sample_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_word <= '0;
      frame_toggle <= 1'b0;
    end else if (bit_count == `DACS_LAST_BIT) begin
      frame_word <= {shift_in, i_serial_data_in};
      frame_toggle <= ~frame_toggle;
    end
  end

  // returned byte
  // The byte read by the previous frame goes out first, top bit first,
  // launched on the edge opposite to sampling. It is stable for the
  // whole frame. In phase 0 the top bit is not presented before the
  // first sample, a limitation the host must allow for.
  always_ff @(negedge sample_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_count <= 4'h0;
      o_serial_data_out <= 1'b0;
    end else if (out_count != `DACS_READ_BITS) begin
      o_serial_data_out <= read_byte[3'(4'h7 - out_count)];
      out_count <= out_count + 4'h1;
    end else begin
      o_serial_data_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Crossing into the system domain.

  // The frame toggle and chip select each pass two flops. Chip select
  // enters inverted, so the flops' reset value matches the idle pin and
  // no false select edge follows reset.
  dacs_sync #(.WIDTH(2)) u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async({frame_toggle, ~i_chip_select_n}),
    .o_sync(synced)
  );

  // Remember the last toggle and selection seen, for edge detection.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      toggle_seen <= 1'b0;
      cs_active_prev <= 1'b0;
    end else begin
      toggle_seen <= synced[1];
      cs_active_prev <= synced[0];
    end
  end

  assign frame_strobe = synced[1] ^ toggle_seen;
  assign cs_fall = ~cs_active_prev & synced[0];

  //////////////////////////////////////////////////////////////////////////
  // Register updates.

  // reserved ignored
  // One updater per configuration register; the mask drops reserved bits.
  for (genvar i = 1; i < `DACS_REG_COUNT; i++) begin : g_cfg
    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cfg[i] <= `DACS_RESET_VALUE;
      end else if (frame_strobe && frame_word.addr == 4'(i)) begin
        cfg[i] <= updated(cfg[i], frame_word);
      end
    end
  end

  // Any modifying command to status clears the flags given as ones.
  assign status_clear_hit = frame_strobe && is_modify(frame_word.cmd) &&
                            frame_word.addr == `DACS_ADDR_STATUS;
  assign status_clear = status_clear_hit ? frame_word.data : 8'h00;

  // wide read flag
  // A new event in the clearing cycle wins, so no event is lost.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wide_read_flag <= 1'b0;
    end else begin
      wide_read_flag <= i_wide_read_active |
        (wide_read_flag & ~status_clear[`DACS_BIT_WIDE_READ]);
    end
  end

  // averaging abort
  // Chip select falling while averaging still runs marks an abort.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      averaging_abort_flag <= 1'b0;
    end else begin
      averaging_abort_flag <= (cs_fall & i_averaging_busy) |
        (averaging_abort_flag & ~status_clear[`DACS_BIT_AVG_ABORT]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Readback.

  // status reserved zero
  // Status view carries only the two flags; the rest is tied low.
  always_comb begin
    view[0] = 8'h00;
    view[0][`DACS_BIT_WIDE_READ] = wide_read_flag;
    view[0][`DACS_BIT_AVG_ABORT] = averaging_abort_flag;
    view[1] = cfg[1];
    view[2] = cfg[2];
    view[3] = cfg[3];
  end

  // latch read
  // The read byte is caught at the end of the read frame and shifted out
  // in the next one; unmapped addresses read zero.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_byte <= 8'h00;
    end else if (frame_strobe && frame_word.cmd == `DACS_CMD_READ) begin
      read_byte <= view[frame_word.addr[1:0]] & writable(frame_word.addr);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  // power controls
  // Power, clock mode and lane width outputs follow the registers a cycle
  // later, keeping every output on its own flop.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_power <= '0;
      o_serial_clock_polarity <= 1'b0;
      o_serial_clock_phase <= 1'b0;
      edge_select <= 1'b0;
      o_output_lane_width <= 2'h0;
      o_status <= 8'h00;
    end else begin
      o_power.half_reference_off <= cfg[1][`DACS_BIT_HALF_REF];
      o_power.second_channel_off <= cfg[1][`DACS_BIT_SECOND_CH];
      o_power.first_channel_off <= cfg[1][`DACS_BIT_FIRST_CH];
      o_power.internal_reference_off <= cfg[1][`DACS_BIT_INT_REF];
      o_serial_clock_polarity <= cfg[2][`DACS_BIT_POLARITY];
      o_serial_clock_phase <= cfg[2][`DACS_BIT_PHASE];
      edge_select <= cfg[2][`DACS_BIT_POLARITY] ^ cfg[2][`DACS_BIT_PHASE];
      o_output_lane_width <= cfg[3][1:0];
      o_status <= view[0];
    end
  end

  // protocol decode
  // The top field bit alone selects parallel bytes.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_readout_mode <= dacs_pkg::DACS_SERIAL_SDR;
    end else begin
      case (cfg[2][`DACS_PROTO_MSB:`DACS_PROTO_LSB])
        3'h0: o_readout_mode <= dacs_pkg::DACS_SERIAL_SDR;
        3'h1: o_readout_mode <= dacs_pkg::DACS_SERIAL_DDR;
        3'h2: o_readout_mode <= dacs_pkg::DACS_RETIMER_SDR;
        3'h3: o_readout_mode <= dacs_pkg::DACS_RETIMER_DDR;
        default: o_readout_mode <= dacs_pkg::DACS_PARALLEL;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  AST_WIDE_READ_SET: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_wide_read_active |-> ##2 o_status[`DACS_BIT_WIDE_READ])
    else $error("wide read flag not reported");

  AST_AVG_ABORT_SET: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (cs_fall && i_averaging_busy) |=> averaging_abort_flag)
    else $error("averaging abort not flagged");

  AST_STATUS_RESERVED: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_status[7:3] == 5'h00 && !o_status[0])
    else $error("status reserved bit set");

  AST_HALF_REF_WRITE: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (frame_strobe && frame_word.cmd == `DACS_CMD_WRITE &&
     frame_word.addr == `DACS_ADDR_POWER)
    |-> ##2 o_power.half_reference_off ==
        $past(frame_word.data[`DACS_BIT_HALF_REF], 2))
    else $error("half reference control wrong");

  AST_CHANNEL_POWER: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    ##1 o_power.second_channel_off == $past(cfg[1][`DACS_BIT_SECOND_CH]) &&
    o_power.first_channel_off == $past(cfg[1][`DACS_BIT_FIRST_CH]) &&
    o_power.internal_reference_off == $past(cfg[1][`DACS_BIT_INT_REF]))
    else $error("power outputs do not follow register");

  AST_PARALLEL_MODE: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    $rose(cfg[2][`DACS_PROTO_MSB]) |=>
      o_readout_mode == dacs_pkg::DACS_PARALLEL)
    else $error("parallel protocol not selected");

  AST_SERIAL_SDR_MODE: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    cfg[2][6:4] == 3'h0 |=> o_readout_mode == dacs_pkg::DACS_SERIAL_SDR)
    else $error("serial single rate not selected");

  AST_SET_BITS: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (frame_strobe && frame_word.cmd == `DACS_CMD_SET &&
     frame_word.addr == `DACS_ADDR_POWER)
    |=> cfg[1] == (($past(cfg[1]) | $past(frame_word.data)) &
                   `DACS_MASK_POWER))
    else $error("set bit command wrong");

  AST_CLEAR_BITS: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (frame_strobe && frame_word.cmd == `DACS_CMD_CLEAR &&
     frame_word.addr == `DACS_ADDR_POWER)
    |=> cfg[1] == ($past(cfg[1]) & ~$past(frame_word.data)))
    else $error("clear bit command wrong");

  AST_RESERVED_IGNORED: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (cfg[1] & ~`DACS_MASK_POWER) == 8'h00 &&
    (cfg[2] & ~`DACS_MASK_PROTOCOL) == 8'h00)
    else $error("reserved bit stored");

  AST_READ_LATCH: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (frame_strobe && frame_word.cmd == `DACS_CMD_READ &&
     frame_word.addr == `DACS_ADDR_POWER) |=> read_byte == $past(cfg[1]))
    else $error("read byte not latched");

  AST_EDGE_SELECT: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    ##1 edge_select == ($past(cfg[2][1]) ^ $past(cfg[2][0])))
    else $error("sampling edge mismatch");

endmodule : dacs_regs

// ### hw/dacs_sync.sv
// Two-flop synchroniser for levels entering the system clock domain.
// Assumes each bit is a level or a toggle that holds for several clocks.
module dacs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // First stage; read only by the second stage below.
  logic [WIDTH-1:0] meta;

  // Both stages reset to zero, never to the input value.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : dacs_sync

// ### pkg/dacs_params.svh
// Constants for the converter configuration and status register bank.
// Assumes an 8-bit register space reached by 16-bit serial command frames.
`ifndef DACS_PARAMS_SVH
`define DACS_PARAMS_SVH

// Register offsets.
`define DACS_ADDR_STATUS 4'h0
`define DACS_ADDR_POWER 4'h1
`define DACS_ADDR_PROTOCOL 4'h2
`define DACS_ADDR_WIDTH 4'h3
`define DACS_REG_COUNT 4

// Reset value shared by every register.
`define DACS_RESET_VALUE 8'h00

// Bits software may change; every other bit is reserved and reads zero.
`define DACS_MASK_STATUS 8'h06
`define DACS_MASK_POWER 8'h2b
`define DACS_MASK_PROTOCOL 8'h73
`define DACS_MASK_WIDTH 8'h03

// Field positions.
`define DACS_BIT_WIDE_READ 2
`define DACS_BIT_AVG_ABORT 1
`define DACS_BIT_HALF_REF 5
`define DACS_BIT_SECOND_CH 3
`define DACS_BIT_FIRST_CH 1
`define DACS_BIT_INT_REF 0
`define DACS_PROTO_MSB 6
`define DACS_PROTO_LSB 4
`define DACS_BIT_POLARITY 1
`define DACS_BIT_PHASE 0

// Command codes.
`define DACS_CMD_WRITE 4'h1
`define DACS_CMD_READ 4'h2
`define DACS_CMD_SET 4'h5
`define DACS_CMD_CLEAR 4'h6

// Frame timing in serial clock edges.
`define DACS_FRAME_BITS 5'd16
`define DACS_LAST_BIT 5'd15
`define DACS_READ_BITS 4'd8

`endif

// ### pkg/dacs_pkg.sv
// Types shared by the converter register bank and its bench.
// Assumes the constants of dacs_params.svh alongside.
package dacs_pkg;

  // One command frame as it arrives from the host, first bit on top.
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [7:0] data;
  } dacs_frame_s;

  // Power-down controls driven to the analog blocks.
  typedef struct packed {
    logic half_reference_off;
    logic second_channel_off;
    logic first_channel_off;
    logic internal_reference_off;
  } dacs_power_s;

  // Decoded readout protocol, one-hot.
  typedef enum logic [4:0] {
    DACS_SERIAL_SDR = 5'h01,
    DACS_SERIAL_DDR = 5'h02,
    DACS_RETIMER_SDR = 5'h04,
    DACS_RETIMER_DDR = 5'h08,
    DACS_PARALLEL = 5'h10
  } dacs_readout_e;

endpackage : dacs_pkg
